// ==== atm_regs.sv ====
// Purpose: register file, scheduling and limit alerts of the converter monitor
// Assumes: register port and measurement inputs synchronous to MCLK
// Notes: read data appears on the edge after REG_RD; high bytes come from a
//        snapshot taken when the low byte was read
`timescale 1ns/100ps
`default_nettype none
module atm_regs #(
   parameter int MS_CYCLES = atm_pkg::MS_CYCLES
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic MEAS_VALID,
   input wire logic [2:0] MEAS_CHAN,
   input wire logic [11:0] MEAS_DATA,
   input wire logic PANEL_PRESSED,
   input wire logic BATT_CRITICAL,
   input wire logic OVERTEMP,
   output logic [7:0] MEAS_REQ,
   output logic CONV_POWER,
   output logic MODE_TOUCH,
   output logic IRQ
);
   localparam int MS_W = $clog2(MS_CYCLES);
   localparam int NCH = atm_pkg::NUM_CH;
   localparam int NLIM = atm_pkg::NUM_LIM;
   localparam int RW = atm_pkg::RES_W;

   logic [RW-1:0] results [NCH];
   logic [RW-1:0] limits [NLIM];
   logic [7:0] limit_stage;
   logic [3:0] read_shadow;
   logic cfg_power, ot_irq_en, cmp_valid, ms_tick, next_shadow_load;
   logic [7:0] irq_en;
   logic [NCH-1:0] sched_en;
   logic [atm_pkg::EXP_W-1:0] sched_exp [NCH];
   logic temp_above_limit_flag, temp_below_limit_flag;
   logic battery_above_limit_flag, battery_below_limit_flag;
   logic supply_above_limit_flag, supply_below_limit_flag;
   logic [2:0] cmp_chan;
   logic [MS_W-1:0] ms_count;
   logic [NCH-1:0] due, next_pending;
   logic [7:0] status_now, next_rdata;
   logic [3:0] next_shadow;

   // ==========================================================
   // live status byte
   always_comb begin
      status_now = 8'h00;
      status_now[atm_pkg::STAT_PRESS] = PANEL_PRESSED && MODE_TOUCH;
      status_now[atm_pkg::STAT_THI] = temp_above_limit_flag;
      status_now[atm_pkg::STAT_TLO] = temp_below_limit_flag;
      status_now[atm_pkg::STAT_BHI] = battery_above_limit_flag;
      status_now[atm_pkg::STAT_BLO] = battery_below_limit_flag;
      status_now[atm_pkg::STAT_SHI] = supply_above_limit_flag;
      status_now[atm_pkg::STAT_SLO] = supply_below_limit_flag;
      status_now[atm_pkg::STAT_BCRIT] = BATT_CRITICAL;
   end

   // ==========================================================
   // configuration and enables
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         MODE_TOUCH <= atm_pkg::CFG_MODE_RST;
         cfg_power <= atm_pkg::CFG_POWER_RST;
         irq_en <= atm_pkg::IRQ_EN_RST;
         ot_irq_en <= atm_pkg::OT_EN_RST;
      end else if (REG_WR) begin
         if (REG_ADDR == atm_pkg::ADDR_CONFIG) begin
            MODE_TOUCH <= REG_WDATA[atm_pkg::CFG_MODE_BIT];
            cfg_power <= REG_WDATA[atm_pkg::CFG_POWER_BIT];
         end
         if (REG_ADDR == atm_pkg::ADDR_IRQ_EN) begin
            irq_en <= REG_WDATA;
         end
         if (REG_ADDR == atm_pkg::ADDR_OVERTEMP) begin
            ot_irq_en <= REG_WDATA[atm_pkg::OT_EN_BIT];
         end
      end
   end

   // ==========================================================
   // schedule registers
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         for (int i = 0; i < NCH; i++) begin
            sched_en[i] <= atm_pkg::SCHED_EN_RST;
            sched_exp[i] <= atm_pkg::SCHED_EXP_RST;
         end
      end else if (REG_WR) begin
         for (int i = 0; i < NCH; i++) begin
            if (REG_ADDR == atm_pkg::SCHED_ADDR[i]) begin
               sched_en[i] <= REG_WDATA[atm_pkg::SCHED_EN_BIT];
               sched_exp[i] <= REG_WDATA[atm_pkg::SCHED_EXP_LSB +: atm_pkg::EXP_W];
            end
         end
      end
   end

   // ==========================================================
   // limit registers
   // the low byte is staged and both bytes land together on the high-byte
   // write, so the comparator never sees a half-updated limit
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         limit_stage <= 8'h00;
         for (int i = 0; i < NLIM; i++) begin
            limits[i] <= (i % 2 == 0) ? atm_pkg::LIMIT_HI_RST : atm_pkg::LIMIT_LO_RST;
         end
      end else if (REG_WR) begin
         for (int i = 0; i < NLIM; i++) begin
            if (REG_ADDR == atm_pkg::LIMIT_ADDR[i]) begin
               limit_stage <= REG_WDATA;
            end
            if (REG_ADDR == atm_pkg::LIMIT_ADDR[i] + 8'h01) begin
               limits[i] <= {REG_WDATA[3:0], limit_stage};
            end
         end
      end
   end

   // ==========================================================
   // measurement results
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         for (int i = 0; i < NCH; i++) begin
            results[i] <= atm_pkg::RESULT_RST;
         end
      end else if (MEAS_VALID) begin
         results[MEAS_CHAN] <= MEAS_DATA;
      end
   end

   // ==========================================================
   // limit comparison, one cycle after the result is stored
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         cmp_valid <= 1'b0;
         cmp_chan <= 3'h0;
      end else begin
         cmp_valid <= MEAS_VALID;
         cmp_chan <= MEAS_CHAN;
      end
   end

   // flags track the latest sample; they are not sticky
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         temp_above_limit_flag <= 1'b0;
         temp_below_limit_flag <= 1'b0;
         battery_above_limit_flag <= 1'b0;
         battery_below_limit_flag <= 1'b0;
         supply_above_limit_flag <= 1'b0;
         supply_below_limit_flag <= 1'b0;
      end else if (cmp_valid) begin
         if (cmp_chan == atm_pkg::CH_TEMP) begin
            temp_above_limit_flag <= results[cmp_chan] > limits[atm_pkg::LIM_TEMP_HI];
            temp_below_limit_flag <= results[cmp_chan] < limits[atm_pkg::LIM_TEMP_LO];
         end
         if (cmp_chan == atm_pkg::CH_BATT) begin
            battery_above_limit_flag <= results[cmp_chan] > limits[atm_pkg::LIM_BATT_HI];
            battery_below_limit_flag <= results[cmp_chan] < limits[atm_pkg::LIM_BATT_LO];
         end
         if (cmp_chan == atm_pkg::CH_SUPPLY) begin
            supply_above_limit_flag <= results[cmp_chan] > limits[atm_pkg::LIM_SUPPLY_HI];
            supply_below_limit_flag <= results[cmp_chan] < limits[atm_pkg::LIM_SUPPLY_LO];
         end
      end
   end

   // ==========================================================
   // millisecond divider
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         ms_count <= '0;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= ms_count == MS_W'(MS_CYCLES - 1);
         if (ms_count == MS_W'(MS_CYCLES - 1)) begin
            ms_count <= '0;
         end else begin
            ms_count <= MS_W'(ms_count + 1'b1);
         end
      end
   end

   // ==========================================================
   // per-channel schedulers
   for (genvar g = 0; g < NCH; g++) begin : g_sched
      atm_sched_timer #(
         .EXP_W(atm_pkg::EXP_W),
         .CNT_W(atm_pkg::SCHED_CNT_W)
      ) u_timer (
         .clk(MCLK),
         .rst_n(RST_N),
         .ms_tick(ms_tick),
         .enable(sched_en[g]),
         .period_exp(sched_exp[g]),
         .due(due[g])
      );
   end

   // ==========================================================
   // outstanding requests and converter power
   // a new request in the cycle its channel is served stays outstanding
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         next_pending[i] = MEAS_REQ[i];
         if (MEAS_VALID && MEAS_CHAN == 3'(i)) begin
            next_pending[i] = 1'b0;
         end
         if (due[i]) begin
            next_pending[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         MEAS_REQ <= 8'h00;
         CONV_POWER <= 1'b0;
      end else begin
         MEAS_REQ <= next_pending;
         CONV_POWER <= cfg_power || (|next_pending);
      end
   end

   // ==========================================================
   // interrupt request
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= (|(status_now & irq_en)) || (OVERTEMP && ot_irq_en);
      end
   end

   // ==========================================================
   // read decode
   always_comb begin
      next_rdata = 8'h00;
      next_shadow_load = 1'b0;
      next_shadow = 4'h0;
      if (REG_ADDR == atm_pkg::ADDR_STATUS) begin
         next_rdata = status_now;
      end
      if (REG_ADDR == atm_pkg::ADDR_CONFIG) begin
         next_rdata[atm_pkg::CFG_MODE_BIT] = MODE_TOUCH;
         next_rdata[atm_pkg::CFG_POWER_BIT] = cfg_power;
      end
      if (REG_ADDR == atm_pkg::ADDR_IRQ_EN) begin
         next_rdata = irq_en;
      end
      if (REG_ADDR == atm_pkg::ADDR_OVERTEMP) begin
         next_rdata[atm_pkg::OT_FLAG_BIT] = OVERTEMP;
         next_rdata[atm_pkg::OT_EN_BIT] = ot_irq_en;
      end
      for (int i = 0; i < NCH; i++) begin
         if (REG_ADDR == atm_pkg::SCHED_ADDR[i]) begin
            next_rdata[atm_pkg::SCHED_EN_BIT] = sched_en[i];
            next_rdata[atm_pkg::SCHED_EXP_LSB +: atm_pkg::EXP_W] = sched_exp[i];
         end
         if (REG_ADDR == atm_pkg::RESULT_ADDR[i]) begin
            next_rdata = results[i][7:0];
            next_shadow_load = 1'b1;
            next_shadow = results[i][11:8];
         end
         if (REG_ADDR == atm_pkg::RESULT_ADDR[i] + 8'h01) begin
            next_rdata = {4'h0, read_shadow};
         end
      end
      for (int i = 0; i < NLIM; i++) begin
         if (REG_ADDR == atm_pkg::LIMIT_ADDR[i]) begin
            next_rdata = limits[i][7:0];
            next_shadow_load = 1'b1;
            next_shadow = limits[i][11:8];
         end
         if (REG_ADDR == atm_pkg::LIMIT_ADDR[i] + 8'h01) begin
            next_rdata = {4'h0, read_shadow};
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         REG_RDATA <= 8'h00;
         read_shadow <= 4'h0;
      end else if (REG_RD) begin
         REG_RDATA <= next_rdata;
         if (next_shadow_load) begin
            read_shadow <= next_shadow;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   sequence seq_temp_sample;
      MEAS_VALID && MEAS_CHAN == atm_pkg::CH_TEMP ##1 !REG_WR;
   endsequence
   sequence seq_batt_sample;
      MEAS_VALID && MEAS_CHAN == atm_pkg::CH_BATT ##1 !REG_WR;
   endsequence
   chk_status_alerts: assert property (
      REG_RD && REG_ADDR == atm_pkg::ADDR_STATUS
      |=> REG_RDATA[7:1] == $past(status_now[7:1])) else $error("alert flags wrong");
   chk_press_bit: assert property (
      REG_RD && REG_ADDR == atm_pkg::ADDR_STATUS
      |=> REG_RDATA[0] == $past(PANEL_PRESSED && MODE_TOUCH)) else $error("press bit wrong");
   chk_result_stored: assert property (
      MEAS_VALID |=> results[$past(MEAS_CHAN)] == $past(MEAS_DATA))
      else $error("result not stored");
   chk_high_nibble_zero: assert property (
      REG_RD && REG_ADDR == atm_pkg::RESULT_ADDR[atm_pkg::CH_TEMP] + 8'h01
      |=> REG_RDATA[7:4] == 4'h0) else $error("reserved result bits not zero");
   chk_limit_commit: assert property (
      REG_WR && REG_ADDR == atm_pkg::LIMIT_ADDR[atm_pkg::LIM_BATT_HI] + 8'h01
      |=> limits[atm_pkg::LIM_BATT_HI] == {$past(REG_WDATA[3:0]), $past(limit_stage)})
      else $error("limit not committed");
   chk_temp_compare: assert property (
      seq_temp_sample |=> temp_above_limit_flag
         == (results[atm_pkg::CH_TEMP] > limits[atm_pkg::LIM_TEMP_HI]))
      else $error("temperature high flag wrong");
   chk_batt_compare: assert property (
      seq_batt_sample |=> battery_below_limit_flag
         == (results[atm_pkg::CH_BATT] < limits[atm_pkg::LIM_BATT_LO]))
      else $error("battery low flag wrong");
   chk_irq_follows: assert property (
      (|(status_now & irq_en)) |=> IRQ) else $error("enabled flag gave no interrupt");
   chk_irq_cause: assert property (
      IRQ |-> $past(|(status_now & irq_en)) || $past(OVERTEMP && ot_irq_en))
      else $error("interrupt without enabled cause");
   chk_power_on: assert property (
      cfg_power |=> CONV_POWER) else $error("converter not held powered");
   chk_overtemp_read: assert property (
      REG_RD && REG_ADDR == atm_pkg::ADDR_OVERTEMP
      |=> REG_RDATA[0] == $past(OVERTEMP)) else $error("overtemp bit wrong");
   chk_snapshot: assert property (
      REG_RD && REG_ADDR == atm_pkg::RESULT_ADDR[atm_pkg::CH_BATT] ##1
      REG_RD && REG_ADDR == atm_pkg::RESULT_ADDR[atm_pkg::CH_BATT] + 8'h01
      |=> REG_RDATA[3:0] == $past(results[atm_pkg::CH_BATT][11:8], 2)) else $error("torn read");
endmodule : atm_regs
`default_nettype wire

// ==== atm_pkg.sv ====
// Purpose: shared constants for the converter monitor register block
// Assumes: byte-wide register port, one 40 MHz clock
// Notes: result and limit registers span two byte addresses, low byte first
package atm_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_PERIOD_NS = 1000000;
   localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
   // ==========================================================
   // widths and channel numbering
   localparam int NUM_CH = 8;
   localparam int NUM_LIM = 6;
   localparam int RES_W = 12;
   localparam int EXP_W = 4;
   localparam int SCHED_CNT_W = 16;
   localparam logic [2:0] CH_SUPPLY = 3'h4;
   localparam logic [2:0] CH_CHARGE = 3'h5;
   localparam logic [2:0] CH_TEMP = 3'h6;
   localparam logic [2:0] CH_BATT = 3'h7;
   // limit slots: supply hi/lo, battery hi/lo, temperature hi/lo
   localparam int LIM_SUPPLY_HI = 0;
   localparam int LIM_SUPPLY_LO = 1;
   localparam int LIM_BATT_HI = 2;
   localparam int LIM_BATT_LO = 3;
   localparam int LIM_TEMP_HI = 4;
   localparam int LIM_TEMP_LO = 5;
   // ==========================================================
   // byte addresses
   localparam logic [7:0] ADDR_STATUS = 8'hC0;
   localparam logic [7:0] RESULT_ADDR [NUM_CH] =
      '{8'hC1, 8'hC3, 8'hC5, 8'hC7, 8'hCD, 8'hCF, 8'hCB, 8'hC9};
   localparam logic [7:0] ADDR_CONFIG = 8'hD1;
   localparam logic [7:0] ADDR_IRQ_EN = 8'hD2;
   localparam logic [7:0] SCHED_ADDR [NUM_CH] =
      '{8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hDA};
   localparam logic [7:0] LIMIT_ADDR [NUM_LIM] =
      '{8'hDB, 8'hDD, 8'hDF, 8'hE1, 8'hE3, 8'hE5};
   localparam logic [7:0] ADDR_OVERTEMP = 8'hE7;
   // ==========================================================
   // field positions
   localparam int STAT_PRESS = 0;
   localparam int STAT_THI = 1;
   localparam int STAT_TLO = 2;
   localparam int STAT_BHI = 3;
   localparam int STAT_BLO = 4;
   localparam int STAT_SHI = 5;
   localparam int STAT_SLO = 6;
   localparam int STAT_BCRIT = 7;
   localparam int CFG_MODE_BIT = 0;
   localparam int CFG_POWER_BIT = 2;
   localparam int SCHED_EN_BIT = 0;
   localparam int SCHED_EXP_LSB = 4;
   localparam int OT_FLAG_BIT = 0;
   localparam int OT_EN_BIT = 4;
   // ==========================================================
   // reset values
   localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
   localparam logic [RES_W-1:0] LIMIT_HI_RST = 12'hFFF;
   localparam logic [RES_W-1:0] LIMIT_LO_RST = 12'h000;
   localparam logic CFG_MODE_RST = 1'h0;
   localparam logic CFG_POWER_RST = 1'h0;
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam logic SCHED_EN_RST = 1'h0;
   localparam logic [EXP_W-1:0] SCHED_EXP_RST = 4'h0;
   localparam logic OT_EN_RST = 1'h0;
endpackage : atm_pkg

// ==== atm_sched_timer.sv ====
// Purpose: per-channel periodic measurement scheduler
// Assumes: ms_tick is a one-cycle pulse every millisecond
// Notes: period is 2 to the power period_exp milliseconds
`timescale 1ns/100ps
`default_nettype none
module atm_sched_timer #(
   parameter int EXP_W = 4,
   parameter int CNT_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ms_tick,
   input wire logic enable,
   input wire logic [EXP_W-1:0] period_exp,
   output logic due
);
   logic [CNT_W-1:0] ms_count;
   logic [CNT_W-1:0] last_count;

   assign last_count = (CNT_W'(1) << period_exp) - CNT_W'(1);

   // ==========================================================
   // millisecond counter
   // disabling restarts the count, so a re-enable waits one full period
   always_ff @(posedge clk) begin
      if (!rst_n || !enable) begin
         ms_count <= '0;
         due <= 1'b0;
      end else begin
         due <= 1'b0;
         if (ms_tick) begin
            if (ms_count == last_count) begin
               ms_count <= '0;
               due <= 1'b1;
            end else begin
               ms_count <= CNT_W'(ms_count + 1'b1);
            end
         end
      end
   end

   // ==========================================================
   // checks
   chk_due_disabled: assert property (@(posedge clk) disable iff (!rst_n)
      !enable |=> !due)
      else $error("scheduler fired while disabled");
   chk_due_on_tick: assert property (@(posedge clk) disable iff (!rst_n)
      due |-> $past(ms_tick) && $past(ms_count) == $past(last_count))
      else $error("scheduler fired off its period");
endmodule : atm_sched_timer
`default_nettype wire

// ==== atm_conv_model.sv ====
// Purpose: converter stand-in that answers scheduled measurement requests
// Assumes: one request served at a time, lowest channel first
// Notes: data lines toggle between answers so a stale value never matches
`timescale 1ns/100ps
`default_nettype none
module atm_conv_model #(
   parameter int LAT = 2
) (
   input wire logic clk,
   input wire logic [7:0] req,
   input wire logic [11:0] reply [8],
   output logic valid,
   output logic [2:0] chan,
   output logic [11:0] data
);
   int wait_cnt = 0;
   initial begin
      valid = 1'b0;
      chan = 3'h0;
      data = 12'h000;
   end
   // ==========================================================
   // answer LAT+1 cycles after a request is seen; the real converter is never instant
   always @(posedge clk) begin
      valid <= 1'b0;
      data <= ~data;
      if (valid || req == 8'h00) begin
         wait_cnt <= 0;
      end else if (wait_cnt < LAT) begin
         wait_cnt <= wait_cnt + 1;
      end else begin
         wait_cnt <= 0;
         valid <= 1'b1;
         for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
               chan <= i[2:0];
               data <= reply[i];
            end
         end
      end
   end
endmodule : atm_conv_model
`default_nettype wire

// ==== atm_regs_tb_top.sv ====
// Purpose: self-checking bench of the converter monitor registers
// Assumes: millisecond shortened to 8 clocks
// Notes: measurements only come through the scheduler and the model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("FAIL %0t mismatch %0h vs %0h", $time, (g), (e)); \
   end \
end
module atm_regs_tb_top;
   localparam int MSC = 8;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic press = 1'b0;
   logic crit = 1'b0;
   logic hot = 1'b0;
   logic [7:0] rdata;
   logic mvalid;
   logic [2:0] mchan;
   logic [11:0] mdata;
   logic [7:0] req;
   logic pwr;
   logic touch;
   logic irq;
   logic [11:0] reply [8];
   int errors = 0;
   int samples_checked = 0;
   atm_regs #(.MS_CYCLES(MSC)) dut (.MCLK(mclk), .RST_N(rst_n), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .MEAS_VALID(mvalid), .MEAS_CHAN(mchan), .MEAS_DATA(mdata),
      .PANEL_PRESSED(press), .BATT_CRITICAL(crit), .OVERTEMP(hot),
      .MEAS_REQ(req), .CONV_POWER(pwr), .MODE_TOUCH(touch), .IRQ(irq));
   atm_conv_model conv (.clk(mclk), .req(req), .reply(reply), .valid(mvalid),
      .chan(mchan), .data(mdata));
   // ==========================================================
   // register port
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr8
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd8
   // low and high byte back to back, as software would read a result
   task automatic rd16(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      addr <= 8'(a + 8'h01);
      #1 d[7:0] = rdata;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d[15:8] = rdata;
   endtask : rd16
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr8(a, d[7:0]);
      wr8(8'(a + 8'h01), d[15:8]);
   endtask : wr16
   // ==========================================================
   // scenarios
   task automatic t_reset;
      logic [15:0] v;
      for (int i = 0; i < 8; i++) begin
         rd16(atm_pkg::RESULT_ADDR[i], v);
         `CHK(v, 16'h0000)
         rd8(atm_pkg::SCHED_ADDR[i], v[7:0]);
         `CHK(v[7:0], 8'h00)
      end
      for (int i = 0; i < 6; i++) begin
         rd16(atm_pkg::LIMIT_ADDR[i], v);
         `CHK(v, (i % 2) ? 16'h0000 : 16'h0FFF)
      end
      rd8(8'hD1, v[7:0]);
      `CHK(v[7:0], 8'h00)
      rd8(8'hD2, v[7:0]);
      `CHK(v[7:0], 8'h00)
      rd8(8'hE7, v[7:0]);
      `CHK(v[7:0], 8'h00)
      rd8(8'hC0, v[7:0]);
      `CHK(v[7:0], 8'h00)
      rd8(8'hE9, v[7:0]);
      `CHK(v[7:0], 8'h00)
   endtask : t_reset
   task automatic t_config;
      logic [7:0] v;
      wr8(8'hD1, 8'hFF);
      rd8(8'hD1, v);
      `CHK(v, 8'h05)
      `CHK({touch, pwr}, 2'h3)
      @(posedge mclk);
      press <= 1'b1;
      rd8(8'hC0, v);
      `CHK(v[0], 1'b1)
      wr8(8'hD1, 8'h00);
      rd8(8'hC0, v);
      `CHK(v[0], 1'b0)
      `CHK({touch, pwr}, 2'h0)
   endtask : t_config
   task automatic t_limits;
      logic [15:0] v;
      wr16(8'hDB, 16'h03FF);
      wr16(8'hE1, 16'h0800);
      wr16(8'hE5, 16'h0700);
      wr16(8'hDF, 16'h0E00);
      rd16(8'hDF, v);
      `CHK(v, 16'h0E00)
      wr16(8'hE3, 16'hFABC);
      rd16(8'hE3, v);
      `CHK(v, 16'h0ABC)
      rd16(8'hE1, v);
      `CHK(v, 16'h0800)
      wr16(8'hE3, 16'h0FFF);
   endtask : t_limits
   task automatic t_sched(input int ch, input int p);
      int t0;
      int t1;
      wr8(atm_pkg::SCHED_ADDR[ch], {p[3:0], 4'h1});
      t0 = 0;
      while (!req[ch] && t0 < 100) begin
         @(posedge mclk);
         #1 t0++;
      end
      `CHK(t0 >= (2 ** p - 1) * MSC && t0 <= (2 ** p) * MSC + 3, 1'b1)
      `CHK(pwr, 1'b1)
      t1 = 0;
      while (req[ch] && t1 < 100) begin
         @(posedge mclk);
         #1 t1++;
      end
      while (!req[ch] && t1 < 100) begin
         @(posedge mclk);
         #1 t1++;
      end
      `CHK(t1 >= (2 ** p) * MSC - 1 && t1 <= (2 ** p) * MSC + 1, 1'b1)
      wr8(atm_pkg::SCHED_ADDR[ch], 8'h00);
      t0 = 0;
      while (req[ch] && t0 < 20) begin
         @(posedge mclk);
         #1 t0++;
      end
      @(posedge mclk);
      #1 `CHK({req[ch], pwr}, 2'h0)
   endtask : t_sched
   task automatic t_results;
      logic [15:0] v;
      for (int i = 0; i < 8; i++) begin
         rd16(atm_pkg::RESULT_ADDR[i], v);
         `CHK(v, {4'h0, reply[i]})
      end
      rd8(8'hC0, v[7:0]);
      `CHK(v[7:0], 8'hB4)
      wr8(8'hD2, 8'h04);
      @(posedge mclk);
      #1 `CHK(irq, 1'b1)
      wr8(8'hD2, 8'h08);
      @(posedge mclk);
      #1 `CHK(irq, 1'b0)
      wr8(8'hD2, 8'h80);
      @(posedge mclk);
      #1 `CHK(irq, 1'b1)
      wr8(8'hD2, 8'h00);
      hot <= 1'b1;
      rd8(8'hE7, v[7:0]);
      `CHK({irq, v[7:0]}, 9'h001)
      wr8(8'hE7, 8'hFF);
      rd8(8'hE7, v[7:0]);
      `CHK({irq, v[7:0]}, 9'h111)
      wr8(8'hE7, 8'h00);
   endtask : t_results
   task automatic t_tear;
      logic [15:0] v;
      rd8(8'hCB, v[7:0]);
      reply[6] = 12'h9A5;
      t_sched(6, 0);
      rd8(8'hCC, v[15:8]);
      `CHK(v[15:8], 8'h06)
      rd16(8'hCB, v);
      `CHK(v, 16'h09A5)
      rd8(8'hC0, v[7:0]);
      `CHK(v[2], 1'b0)
   endtask : t_tear
   task automatic summarize;
      if (errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   // ==========================================================
   // clock, watchdog, main sequence
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      #(20000 * 25);
      errors++;
      summarize();
   end
   initial begin
      for (int i = 0; i < 8; i++) begin
         reply[i] = 12'(i * 256 + 8'hA5);
      end
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_config();
      t_limits();
      crit <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         t_sched(i, i % 3);
      end
      t_results();
      t_tear();
      summarize();
   end
endmodule : atm_regs_tb_top
`default_nettype wire
